// ===== verilog/ctr_pkg.sv
/*
  Package for the code transfer receiver: image layouts, control bit
  positions, register offsets and reset values.
  Assumes a single 125 MHz clock domain shared by both ends.
*/
package ctr_pkg;
  localparam int PAYLOAD_BYTES = 64;
  localparam int SEQ_W         = 16;
  localparam int LEN_W         = 16;
  localparam int PAYLOAD_W     = PAYLOAD_BYTES * 8;

  // Output image control word bits
  localparam int CTL_XFER_EN_BIT   = 0;
  localparam int CTL_HANDSHAKE_BIT = 1;
  // Input image status word bits
  localparam int STS_TRUNC_BIT     = 0;

  // Controller register map, byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_ST = 8'h08;
  localparam logic [7:0] REG_IRQ_EN = 8'h0C;
  localparam logic [7:0] REG_IRQ_CL = 8'h10;
  localparam logic [7:0] REG_SEQ    = 8'h14;
  localparam logic [7:0] REG_LEN    = 8'h18;
  localparam logic [7:0] REG_DATA   = 8'h40;
  localparam logic [7:0] REG_DATA_END = 8'h7C;

  // Interrupt status bits
  localparam int IRQ_FRESH_BIT = 0;
  localparam int IRQ_TRUNC_BIT = 1;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  typedef enum logic {CTR_MODE_BASIC, CTR_MODE_HANDSHAKE} ctr_mode_t;
endpackage : ctr_pkg

// ===== verilog/ctr_image_if.sv
/*
  Cyclic process image interface between cradle and controller.
  Assumes both ends run on clk; one clock is one scan.
*/
interface ctr_image_if (
  input wire logic clk
);
  // Cradle to controller input image
  logic [ctr_pkg::SEQ_W-1:0]     seq_count;
  logic [ctr_pkg::LEN_W-1:0]     payload_byte_count;
  logic [ctr_pkg::PAYLOAD_W-1:0] payload;
  logic [7:0]                    status_word;
  // Controller to cradle output image
  logic [7:0]                    control_word;
  logic [ctr_pkg::SEQ_W-1:0]     ack_count;

  modport cradle (
    input  clk,
    output seq_count,
    output payload_byte_count,
    output payload,
    output status_word,
    input  control_word,
    input  ack_count
  );
  modport controller (
    input  clk,
    input  seq_count,
    input  payload_byte_count,
    input  payload,
    input  status_word,
    output control_word,
    output ack_count
  );
endinterface : ctr_image_if

// ===== verilog/ctr_cradle_end.sv
/*
  Cradle end: publishes scanned-code records on the input image.
  Assumes user side offers one record at a time with a valid/ready pair.
*/
module ctr_cradle_end (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Image link
  ctr_image_if.cradle                        img,
  // User side: one record per handshake
  input  wire logic                          rec_valid,
  output logic                               rec_ready,
  input  wire logic [ctr_pkg::LEN_W-1:0]     rec_len,
  input  wire logic [ctr_pkg::PAYLOAD_W-1:0] rec_data,
  // Control word seen from the controller
  output logic                               xfer_enabled,
  output logic                               handshake_mode
);
  logic                          busy;
  logic [ctr_pkg::SEQ_W-1:0]     seq_r;
  logic [ctr_pkg::LEN_W-1:0]     len_r;
  logic [ctr_pkg::PAYLOAD_W-1:0] data_r;
  logic                          trunc_r;
  logic                          take;

  assign xfer_enabled   = img.control_word[ctr_pkg::CTL_XFER_EN_BIT];
  assign handshake_mode = img.control_word[ctr_pkg::CTL_HANDSHAKE_BIT];
  // In handshake mode wait for the controller to acknowledge
  assign busy      = handshake_mode && (img.ack_count != seq_r);
  assign rec_ready = xfer_enabled && !busy && !sys_rst;
  assign take      = rec_valid && rec_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_r   <= '0;
      len_r   <= '0;
      data_r  <= '0;
      trunc_r <= 1'b0;
    end else if (take) begin
      // Skip zero on wrap so zero stays a reset marker
      seq_r <= (seq_r == {ctr_pkg::SEQ_W{1'b1}}) ? ctr_pkg::SEQ_W'(1) : seq_r + 1'b1;
      if (rec_len > ctr_pkg::LEN_W'(ctr_pkg::PAYLOAD_BYTES)) begin
        len_r   <= ctr_pkg::LEN_W'(ctr_pkg::PAYLOAD_BYTES);
        trunc_r <= 1'b1;
      end else begin
        len_r   <= rec_len;
        trunc_r <= 1'b0;
      end
      data_r <= rec_data;
    end
  end

  assign img.seq_count          = seq_r;
  assign img.payload_byte_count = len_r;
  assign img.payload            = data_r;
  assign img.status_word        = {7'h00, trunc_r};
endmodule : ctr_cradle_end

// ===== verilog/ctr_code_receive_handler.sv
/*
  Controller end: code_receive_handler with AXI4-Lite register access.
  Assumes the image comes from logic on the same clock.
*/
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module ctr_code_receive_handler (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Image link
  ctr_image_if.controller  img,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Events
  output logic             fresh_record_pulse,
  output logic             irq
);
  localparam int SW = ctr_pkg::SEQ_W;

  logic [31:0]                   ctrl_r;
  logic [7:0]                    ctl_out_r;
  logic [SW-1:0]                 ack_r;
  logic [SW-1:0]                 previous_sequence_value;
  logic                          transfer_enable_tracker;
  logic                          fresh_record_latch;
  logic [SW-1:0]                 smp_seq;
  logic [ctr_pkg::LEN_W-1:0]     smp_len;
  logic [ctr_pkg::PAYLOAD_W-1:0] smp_data;
  logic                          smp_trunc;
  logic                          smp_valid_r;
  logic [SW-1:0]                 rec_seq_r;
  logic [ctr_pkg::LEN_W-1:0]     rec_len_r;
  logic [7:0]                    code_record_store [ctr_pkg::PAYLOAD_BYTES];
  logic                          rec_trunc_r;
  logic [1:0]                    irq_st_r;
  logic [1:0]                    irq_en_r;
  logic                          fresh;
  logic                          transfer_enable_param;
  ctr_pkg::ctr_mode_t            mode;
  logic [7:0]                    aw_r;
  logic                          aw_have_r;
  logic [31:0]                   w_r;
  logic                          w_have_r;
  logic                          do_write;
  logic [1:0]                    clr_w;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : strb_merge

  assign transfer_enable_param = ctrl_r[ctr_pkg::CTL_XFER_EN_BIT];
  assign mode = ctrl_r[ctr_pkg::CTL_HANDSHAKE_BIT] ? ctr_pkg::CTR_MODE_HANDSHAKE : ctr_pkg::CTR_MODE_BASIC;

  // Take one consistent snapshot of the input image per scan
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smp_seq     <= '0;
      smp_len     <= '0;
      smp_data    <= '0;
      smp_trunc   <= 1'b0;
      smp_valid_r <= 1'b0;
    end else begin
      smp_seq     <= img.seq_count;
      smp_len     <= img.payload_byte_count;
      smp_data    <= img.payload;
      smp_trunc   <= img.status_word[ctr_pkg::STS_TRUNC_BIT];
      smp_valid_r <= 1'b1;
    end
  end

  // Evaluated every clock, equality test so wraparound is a change
  always_comb begin
    fresh = 1'b0;
    if (transfer_enable_tracker && smp_valid_r) begin
      if (mode == ctr_pkg::CTR_MODE_HANDSHAKE) begin
        fresh = (smp_seq != '0) && (smp_seq != ack_r);
      end else begin
        fresh = (smp_seq != previous_sequence_value);
      end
    end
  end

  // Output image control word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_out_r               <= 8'h00;
      transfer_enable_tracker <= 1'b0;
    end else begin
      ctl_out_r <= 8'h00;
      ctl_out_r[ctr_pkg::CTL_XFER_EN_BIT]   <= transfer_enable_param;
      ctl_out_r[ctr_pkg::CTL_HANDSHAKE_BIT] <= transfer_enable_param &&
                                              (mode == ctr_pkg::CTR_MODE_HANDSHAKE);
      transfer_enable_tracker <= transfer_enable_param;
    end
  end

  // Sequence reference and acknowledge counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      previous_sequence_value <= '0;
      ack_r                   <= '0;
    end else begin
      if (smp_valid_r) previous_sequence_value <= smp_seq;
      if (mode == ctr_pkg::CTR_MODE_HANDSHAKE && smp_seq == '0) begin
        ack_r <= '0;
      end else if (fresh && mode == ctr_pkg::CTR_MODE_HANDSHAKE) begin
        ack_r <= smp_seq;
      end
    end
  end

  // Record store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rec_seq_r   <= '0;
      rec_len_r   <= '0;
      rec_trunc_r <= 1'b0;
      for (int i = 0; i < ctr_pkg::PAYLOAD_BYTES; i++) code_record_store[i] <= 8'h00;
    end else if (fresh) begin
      rec_seq_r   <= smp_seq;
      rec_len_r   <= smp_len;
      rec_trunc_r <= smp_trunc;
      for (int i = 0; i < ctr_pkg::PAYLOAD_BYTES; i++) code_record_store[i] <= smp_data[i*8 +: 8];
    end
  end

  // One scan pulse per detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fresh_record_latch <= 1'b0;
      fresh_record_pulse <= 1'b0;
    end else begin
      fresh_record_latch <= fresh;
      fresh_record_pulse <= fresh;
    end
  end

  // AXI4-Lite write path: address and data in either order
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign clr_w    = (do_write && aw_r == ctr_pkg::REG_IRQ_CL) ? w_r[1:0] : 2'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_r          <= 8'h00;
      aw_have_r     <= 1'b0;
      w_r           <= 32'h0000_0000;
      w_have_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ctr_pkg::RESP_OKAY;
      ctrl_r        <= ctr_pkg::CTRL_RESET;
      irq_en_r      <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r      <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r      <= strb_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
        w_have_r <= 1'b1;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ctr_pkg::RESP_OKAY;
        case ({aw_r[7:2], 2'b00})
          ctr_pkg::REG_CTRL:   ctrl_r   <= {30'h0, w_r[1:0]};
          ctr_pkg::REG_IRQ_EN: irq_en_r <= w_r[1:0];
          ctr_pkg::REG_IRQ_CL: ;
          default:             s_axi_bresp <= ctr_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_st_r <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_st_r[ctr_pkg::IRQ_FRESH_BIT] <= fresh || (irq_st_r[ctr_pkg::IRQ_FRESH_BIT] && !clr_w[ctr_pkg::IRQ_FRESH_BIT]);
      irq_st_r[ctr_pkg::IRQ_TRUNC_BIT] <= (fresh && smp_trunc) ||
                                          (irq_st_r[ctr_pkg::IRQ_TRUNC_BIT] && !clr_w[ctr_pkg::IRQ_TRUNC_BIT]);
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ctr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ctr_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr >= ctr_pkg::REG_DATA && s_axi_araddr <= ctr_pkg::REG_DATA_END) begin
          for (int b = 0; b < 4; b++) begin
            s_axi_rdata[b*8 +: 8] <= code_record_store[{s_axi_araddr[5:2], 2'(b)}];
          end
        end else begin
          case ({s_axi_araddr[7:2], 2'b00})
            ctr_pkg::REG_CTRL:   s_axi_rdata <= ctrl_r;
            ctr_pkg::REG_STATUS: s_axi_rdata <= {29'h0, rec_trunc_r, fresh_record_latch, transfer_enable_tracker};
            ctr_pkg::REG_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_r};
            ctr_pkg::REG_IRQ_EN: s_axi_rdata <= {30'h0, irq_en_r};
            ctr_pkg::REG_IRQ_CL: s_axi_rdata <= 32'h0000_0000;
            ctr_pkg::REG_SEQ:    s_axi_rdata <= {16'h0, rec_seq_r};
            ctr_pkg::REG_LEN:    s_axi_rdata <= {16'h0, rec_len_r};
            default:             s_axi_rresp <= ctr_pkg::RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign img.control_word = ctl_out_r;
  assign img.ack_count    = ack_r;
endmodule : ctr_code_receive_handler

// ===== tb/ctr_image_monitor.sv
/*
  Checker on the image link between cradle end and controller end.
  Assumes clk is the scan clock and sys_rst covers a reset of either end.
*/
module ctr_image_monitor (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // Input image
  input wire logic [ctr_pkg::SEQ_W-1:0] seq_count,
  input wire logic [ctr_pkg::LEN_W-1:0] payload_byte_count,
  input wire logic [7:0]                status_word,
  // Output image
  input wire logic [7:0]                control_word,
  input wire logic [ctr_pkg::SEQ_W-1:0] ack_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_len_max; payload_byte_count <= 16'h0040; endproperty
  a_len_max: assert property (p_len_max) else $error("payload count above 64");
  property p_trunc_full; status_word[0] |-> payload_byte_count == 16'h0040; endproperty
  a_trunc_full: assert property (p_trunc_full) else $error("truncation without full payload");
  property p_hs_en; control_word[1] |-> control_word[0]; endproperty
  a_hs_en: assert property (p_hs_en) else $error("handshake select without enable");
  property p_seq_nz; $changed(seq_count) |-> seq_count != 16'h0000; endproperty
  a_seq_nz: assert property (p_seq_nz) else $error("sequence changed to zero");
  property p_seq_en; $changed(seq_count) |-> $past(control_word[0]); endproperty
  a_seq_en: assert property (p_seq_en) else $error("record sent while disabled");
  // Cradle must not overrun an unacknowledged record
  property p_hs_wait;
    $past(control_word[1]) && $changed(seq_count) |-> $past(ack_count) == $past(seq_count);
  endproperty
  a_hs_wait: assert property (p_hs_wait) else $error("record replaced before ack");
  property p_ack_zero; (control_word[1] && seq_count == 16'h0000) [*3] |-> ack_count == 16'h0000; endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack not cleared on zero sequence");
  property p_ack_copy;
    control_word[1] && seq_count != 16'h0000 && seq_count != ack_count |-> ##[1:4] ack_count == seq_count;
  endproperty
  a_ack_copy: assert property (p_ack_copy) else $error("pending record not acknowledged");
  property p_ack_src; $changed(ack_count) && ack_count != 16'h0000 |-> ack_count == seq_count; endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack differs from sequence");
endmodule : ctr_image_monitor

// ===== tb/test_code_transfer_receiver.sv
/*
  Bench joining cradle end and controller end through the image interface.
  Assumes the register map of ctr_pkg and a 125 MHz scan clock.
*/
module test_code_transfer_receiver;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0, sys_rst = 1'b1, cr_rst = 1'b0, rec_valid = 1'b0, rec_ready;
  logic [15:0]  rec_len = 16'h0000;
  logic [511:0] rec_data = '0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, fresh, irq, cr_xfer, cr_hs;
  logic [1:0]   bresp, rresp;
  int           n_fail = 0, n_tests = 0, n_fresh = 0, cyc = 0;

  ctr_image_if img (.clk(clk));
  ctr_cradle_end i_ctr_cradle_end (.clk(clk), .sys_rst(sys_rst | cr_rst), .img(img), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_len(rec_len), .rec_data(rec_data), .xfer_enabled(cr_xfer), .handshake_mode(cr_hs));
  ctr_code_receive_handler i_ctr_code_receive_handler (.clk(clk), .sys_rst(sys_rst), .img(img),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fresh_record_pulse(fresh), .irq(irq));
  ctr_image_monitor i_ctr_image_monitor (.clk(clk), .sys_rst(sys_rst | cr_rst), .seq_count(img.seq_count),
    .payload_byte_count(img.payload_byte_count), .status_word(img.status_word),
    .control_word(img.control_word), .ack_count(img.ack_count));

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fresh === 1'b1) n_fresh <= n_fresh + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic push(input logic [15:0] l, input logic [31:0] w);
    @(posedge clk);
    rec_len <= l;
    rec_data <= {~w, 448'h0, w};
    rec_valid <= 1'b1;
    do @(posedge clk); while (!rec_ready);
    rec_valid <= 1'b0;
  endtask : push
  // Extra edges let a second pulse show up if it wrongly lasts two scans
  task automatic wait_fresh(input int k);
    int t = 0;
    while (n_fresh < k && t < 30) begin
      @(posedge clk);
      t++;
    end
    repeat (3) @(posedge clk);
    chk(32'(n_fresh), 32'(k));
  endtask : wait_fresh
  task automatic wait_ack(input logic [15:0] v);
    int t = 0;
    while (img.ack_count !== v && t < 30) begin
      @(posedge clk);
      t++;
    end
    chk(32'(img.ack_count), 32'(v));
  endtask : wait_ack

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    axr(ctr_pkg::REG_CTRL, d, r);
    chk(d, ctr_pkg::CTRL_RESET);
    chk(32'(img.control_word), 32'h0);
    axr(8'h20, d, r);
    chk(32'(r), 32'(ctr_pkg::RESP_SLVERR));
    axw(8'h20, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(ctr_pkg::RESP_SLVERR));
  endtask : t_reset
  task automatic t_basic;
    logic [31:0] d;
    logic [1:0]  r;
    axw(ctr_pkg::REG_CTRL, 32'h1, r);
    chk(32'(r), 32'(ctr_pkg::RESP_OKAY));
    // Control word is registered one scan after the write lands
    @(posedge clk);
    chk(32'(img.control_word), 32'h1);
    chk(32'(cr_xfer), 32'h1);
    push(16'h0005, 32'hC0DE_0001);
    wait_fresh(1);
    axr(ctr_pkg::REG_SEQ, d, r);
    chk(d, 32'h1);
    chk(32'(r), 32'(ctr_pkg::RESP_OKAY));
    axr(ctr_pkg::REG_LEN, d, r);
    chk(d, 32'h5);
    axr(ctr_pkg::REG_DATA, d, r);
    chk(d, 32'hC0DE_0001);
    axr(ctr_pkg::REG_DATA_END, d, r);
    chk(d, 32'h3F21_FFFE);
    // Back-to-back records: exactly full, then oversize
    push(16'h0040, 32'hC0DE_0002);
    push(16'h0046, 32'hC0DE_0003);
    wait_fresh(3);
    axr(ctr_pkg::REG_LEN, d, r);
    chk(d, 32'h40);
    axr(ctr_pkg::REG_STATUS, d, r);
    chk(32'(d[2]), 32'h1);
    chk(32'(d[0]), 32'h1);
    axr(ctr_pkg::REG_SEQ, d, r);
    chk(d, 32'h3);
  endtask : t_basic
  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    axw(ctr_pkg::REG_IRQ_EN, 32'h1, r);
    axw(ctr_pkg::REG_IRQ_CL, 32'h3, r);
    push(16'h0003, 32'hC0DE_0004);
    wait_fresh(4);
    chk(32'(irq), 32'h1);
    axr(ctr_pkg::REG_STATUS, d, r);
    chk(32'(d[2]), 32'h0);
    axw(ctr_pkg::REG_IRQ_CL, 32'h1, r);
    axr(ctr_pkg::REG_IRQ_ST, d, r);
    chk(32'(d[0]), 32'h0);
    chk(32'(irq), 32'h0);
    axw(ctr_pkg::REG_IRQ_EN, 32'h0, r);
    push(16'h0002, 32'hC0DE_0005);
    wait_fresh(5);
    axr(ctr_pkg::REG_IRQ_ST, d, r);
    chk(32'(d[0]), 32'h1);
    chk(32'(irq), 32'h0);
  endtask : t_irq
  task automatic t_hs;
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    axw(ctr_pkg::REG_CTRL, 32'h3, r);
    @(posedge clk);
    chk(32'(img.control_word), 32'h3);
    chk(32'(cr_hs), 32'h1);
    wait_ack(16'h0005);
    repeat (3) @(posedge clk);
    k = n_fresh;
    // Second record must wait for the ack of the first
    push(16'h0008, 32'hC0DE_0006);
    push(16'h0009, 32'hC0DE_0007);
    wait_ack(16'h0007);
    wait_fresh(k + 2);
    axr(ctr_pkg::REG_LEN, d, r);
    chk(d, 32'h9);
  endtask : t_hs
  task automatic t_cradle_rst;
    @(posedge clk);
    cr_rst <= 1'b1;
    repeat (3) @(posedge clk);
    cr_rst <= 1'b0;
    wait_ack(16'h0000);
    push(16'h0001, 32'hC0DE_0008);
    wait_ack(16'h0001);
  endtask : t_cradle_rst

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_basic();
    t_irq();
    t_hs();
    t_cradle_rst();
    results();
  end
endmodule : test_code_transfer_receiver
